// file: pcs_pkg.sv
/*
 Shared constants and types of the power-manager control front end:
 register offsets, field positions, reset values, timing counts and
 the packed carriers. Assumes a 250 MHz system clock.
*/
package pcs_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned STAT_FREQ_HZ    = 35_000;
   localparam int unsigned PWM_PERIOD_CYC  = CLK_HZ / STAT_FREQ_HZ;
   localparam int unsigned REGULATOR_THREE_SETTLED_OUT_DELAY_MS   = 230;
   localparam int unsigned REGULATOR_THREE_SETTLED_OUT_DELAY_CYC  = REGULATOR_THREE_SETTLED_OUT_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned BLINK_SLOW_PER  = 8192;
   localparam int unsigned BLINK_FAST_PER  = 2048;
   localparam int unsigned DUTY_DIV        = 8;

   // Counter and field widths
   localparam int unsigned PWM_W  = 13;
   localparam int unsigned BLK_W  = 14;
   localparam int unsigned RST_W  = 26;
   localparam int unsigned SP_W   = 4;
   localparam int unsigned MV_W   = 10;
   localparam int unsigned IRQ_W  = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_SETP     = 8'h04;
   localparam logic [7:0] OFS_STAT     = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

   // Field positions
   localparam int unsigned CTRL_EN_LSB    = 0;
   localparam int unsigned CTRL_ILIM_LSB  = 3;
   localparam int unsigned CTRL_MODE_LSB  = 5;
   localparam int unsigned SETP_R2_LSB    = 0;
   localparam int unsigned SETP_R3_LSB    = 4;
   localparam int unsigned STAT_SETTLED   = 7;
   localparam int unsigned STAT_CHG_EN    = 8;
   localparam int unsigned STAT_PORT_LIVE = 9;
   localparam int unsigned IRQ_TEMP       = 0;
   localparam int unsigned IRQ_BADBAT     = 1;
   localparam int unsigned IRQ_SETTLED    = 2;
   localparam int unsigned IRQ_CHG_END    = 3;

   // Reset values
   localparam logic [2:0]       RST_EN     = 3'h0;
   localparam logic [1:0]       RST_ILIM   = 2'h0;
   localparam logic [1:0]       RST_MODE   = 2'h0;
   localparam logic [SP_W-1:0]  RST_SP     = 4'hF;
   localparam logic [IRQ_W-1:0] RST_MASK   = 4'h0;

   // Set-point scale in millivolts
   localparam logic [MV_W-1:0] FB_MIN_MV  = 10'h1A9;
   localparam logic [MV_W-1:0] FB_STEP_MV = 10'h019;
   localparam logic [SP_W-1:0] SP_FULL    = 4'hF;

   // Effective controls
   typedef struct packed {
      logic [2:0] en;
      logic [1:0] ilim;
      logic [1:0] mode;
   } pcs_ctl_t;

   // Charger condition inputs
   typedef struct packed {
      logic request;
      logic active;
      logic unresponsive;
   } pcs_chg_in_t;

endpackage

// file: pcs_control_select.sv
/*
 Control front end of a power manager with three step-down regulators:
 merges logic pins with software bits, drives the charge-status and
 regulator-3 settled open-drain outputs, raises a masked interrupt.
 Assumes all inputs synchronous to hclk and one AHB-Lite master.
*/
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module pcs_control_select
   import pcs_pkg::*;
#(
   parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC,
   parameter int unsigned REGULATOR_THREE_SETTLED_OUT_DELAY = REGULATOR_THREE_SETTLED_OUT_DELAY_CYC,
   parameter int unsigned BLINK_SLOW = BLINK_SLOW_PER,
   parameter int unsigned BLINK_FAST = BLINK_FAST_PER
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   // Logic pins
   input  wire logic              regulator_one_enable_pin,
   input  wire logic              regulator_two_enable_pin,
   input  wire logic              regulator_three_enable_pin,
   input  wire logic              current_limit_select_lo,
   input  wire logic              current_limit_select_hi,
   input  wire logic              serial_logic_supply,
   input  wire logic              scl_pin_level,
   input  wire logic              sda_pin_level,
   // Analog status
   input  wire logic              regulator_three_feedback_ok,
   input  wire logic              thermistor_input,
   input  wire pcs_chg_in_t       charger,
   // Controls to the analog core
   output pcs_ctl_t               ctl,
   output logic [MV_W-1:0]        regulator_two_feedback_mv,
   output logic [MV_W-1:0]        regulator_three_feedback_mv,
   output logic                   charge_enable,
   // Open-drain outputs
   output logic                   charge_status_out_o,
   output logic                   charge_status_out_oe,
   output logic                   regulator_three_settled_out_o,
   output logic                   regulator_three_settled_out_oe,
   // Interrupt
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////
   // Elaboration checks
   // Blink periods are powers of two so one counter bit sets the phase

   localparam int unsigned SLOW_BIT = $clog2(BLINK_SLOW);
   localparam int unsigned FAST_BIT = $clog2(BLINK_FAST);

   generate
      // Full period must fit the counter, or the high duty wraps to zero
      if (PWM_PERIOD < DUTY_DIV || PWM_PERIOD >= 2**PWM_W) begin : g_bad_pwm
         $error("PWM_PERIOD out of range");
      end
      if (REGULATOR_THREE_SETTLED_OUT_DELAY < 1 || REGULATOR_THREE_SETTLED_OUT_DELAY > 2**RST_W) begin : g_bad_rst
         $error("REGULATOR_THREE_SETTLED_OUT_DELAY out of range");
      end
      if (BLINK_SLOW < 1 || 2**SLOW_BIT != BLINK_SLOW || SLOW_BIT >= BLK_W)
      begin : g_bad_slow
         $error("BLINK_SLOW must be a power of two that fits");
      end
      if (BLINK_FAST < 1 || 2**FAST_BIT != BLINK_FAST || FAST_BIT >= BLK_W)
      begin : g_bad_fast
         $error("BLINK_FAST must be a power of two that fits");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // State
   // One packed state; bus phase fields sit beside the control copy

   typedef struct packed {
      logic [2:0]        reg_en;
      logic [1:0]        reg_ilim;
      logic [1:0]        reg_mode;
      logic [SP_W-1:0]   sp2;
      logic [SP_W-1:0]   sp3;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      logic              ph_pend;
      logic              ph_write;
      logic              ph_hit;
      logic [7:0]        ph_addr;
      logic              hready;
      logic [31:0]       hrdata;
      logic              hresp;
      pcs_ctl_t          ctl;
      logic [MV_W-1:0]   sp2_mv;
      logic [MV_W-1:0]   sp3_mv;
      logic              chg_en;
      logic              chg_oe;
      logic              rst_oe;
      logic              irq;
      logic [PWM_W-1:0]  pwm_cnt;
      logic [BLK_W-1:0]  blk_cnt;
      logic [RST_W-1:0]  rst_cnt;
      logic              settled;
      logic              temp_q;
      logic              bad_q;
      logic              chg_q;
   } pcs_state_t;

   pcs_state_t s_q;
   pcs_state_t s_d;

   ////////////////////////////////////////////////////////////////////
   // Functions
   // Scale and duty arithmetic written once, used on several paths

   // Code to feedback millivolts
   function automatic logic [MV_W-1:0] sp_mv(input logic [SP_W-1:0] code);
      logic [MV_W-1:0] step;
      step = FB_STEP_MV * MV_W'(code);
      return FB_MIN_MV + step;
   endfunction

   // Cycles of pull-down per modulation period
   function automatic logic [PWM_W-1:0] duty_on(input logic high);
      logic [PWM_W-1:0] lo;
      lo = PWM_W'(PWM_PERIOD / DUTY_DIV);
      return high ? PWM_W'(PWM_PERIOD) - lo : lo;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next state
   // Inputs are synchronous to hclk, so no synchronisers stand here

   logic              live;
   logic [SP_W-1:0]   sp2_code;
   logic [SP_W-1:0]   sp3_code;
   logic [IRQ_W-1:0]  clr;
   logic [IRQ_W-1:0]  ev;
   logic              temp_now;
   logic              bad_now;
   logic              chg_now;
   logic              pwm_wrap;
   logic              fast_ph;
   logic              slow_ph;
   logic [31:0]       stat_word;

   always_comb begin
      s_d      = s_q;
      clr      = '0;
      live     = serial_logic_supply;
      sp2_code = live ? s_q.sp2 : SP_FULL;
      sp3_code = live ? s_q.sp3 : SP_FULL;

      // Software bits count only while the port has its supply
      s_d.ctl.en = {regulator_three_enable_pin, regulator_two_enable_pin,
                    regulator_one_enable_pin}
                   | (live ? s_q.reg_en : 3'h0);
      s_d.ctl.ilim = {current_limit_select_hi, current_limit_select_lo}
                     | (live ? s_q.reg_ilim : 2'h0);
      s_d.ctl.mode = live ? s_q.reg_mode
                          : {sda_pin_level, scl_pin_level};
      // Regulator one has no code; its set-point is fixed in the core
      s_d.sp2_mv = sp_mv(sp2_code);
      s_d.sp3_mv = sp_mv(sp3_code);

      // Status word seen by software
      stat_word = '0;
      stat_word[CTRL_EN_LSB +: 3]   = s_q.ctl.en;
      stat_word[CTRL_ILIM_LSB +: 2] = s_q.ctl.ilim;
      stat_word[CTRL_MODE_LSB +: 2] = s_q.ctl.mode;
      stat_word[STAT_SETTLED]       = s_q.settled;
      stat_word[STAT_CHG_EN]        = s_q.chg_en;
      stat_word[STAT_PORT_LIVE]     = live;

      // Bus: address phase, then one wait cycle that does the access
      // A new address phase during that wait is held off by hready low
      if (s_q.ph_pend) begin
         s_d.ph_pend = 1'b0;
         s_d.hready  = 1'b1;
         s_d.hrdata  = '0;
         if (s_q.ph_hit && s_q.ph_write) begin
            case (s_q.ph_addr)
               OFS_CTRL: begin
                  s_d.reg_en   = hwdata[CTRL_EN_LSB +: 3];
                  s_d.reg_ilim = hwdata[CTRL_ILIM_LSB +: 2];
                  s_d.reg_mode = hwdata[CTRL_MODE_LSB +: 2];
               end
               OFS_SETP: begin
                  s_d.sp2 = hwdata[SETP_R2_LSB +: SP_W];
                  s_d.sp3 = hwdata[SETP_R3_LSB +: SP_W];
               end
               OFS_IRQ_STAT: clr = hwdata[IRQ_W-1:0];
               OFS_IRQ_MASK: s_d.irq_mask = hwdata[IRQ_W-1:0];
               default: ;
            endcase
         end else if (s_q.ph_hit) begin
            case (s_q.ph_addr)
               OFS_CTRL: begin
                  s_d.hrdata[CTRL_EN_LSB +: 3]   = s_q.reg_en;
                  s_d.hrdata[CTRL_ILIM_LSB +: 2] = s_q.reg_ilim;
                  s_d.hrdata[CTRL_MODE_LSB +: 2] = s_q.reg_mode;
               end
               OFS_SETP: begin
                  s_d.hrdata[SETP_R2_LSB +: SP_W] = s_q.sp2;
                  s_d.hrdata[SETP_R3_LSB +: SP_W] = s_q.sp3;
               end
               OFS_STAT:     s_d.hrdata = stat_word;
               OFS_IRQ_STAT: s_d.hrdata[IRQ_W-1:0] = s_q.irq_stat;
               OFS_IRQ_MASK: s_d.hrdata[IRQ_W-1:0] = s_q.irq_mask;
               default: ;
            endcase
         end
      end else if (hsel && htrans[1] && hready) begin
         s_d.ph_pend  = 1'b1;
         s_d.hready   = 1'b0;
         s_d.ph_write = hwrite;
         s_d.ph_addr  = haddr[7:0];
         // Only aligned words in the low page are mapped
         s_d.ph_hit   = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0)
                        && (hsize == 3'h2);
      end

      // Charging pauses on bad temperature
      // Temperature wins over the charger request in every cycle
      temp_now   = thermistor_input;
      bad_now    = charger.unresponsive;
      chg_now    = charger.active && !temp_now;
      s_d.chg_en = charger.request && !temp_now;

      // Modulation timebase
      // Free-running, so a fault may start anywhere in the pattern
      pwm_wrap    = (s_q.pwm_cnt == PWM_W'(PWM_PERIOD - 1));
      s_d.pwm_cnt = pwm_wrap ? '0 : s_q.pwm_cnt + 1'b1;
      if (pwm_wrap) begin
         s_d.blk_cnt = s_q.blk_cnt + 1'b1;
      end
      fast_ph = s_q.blk_cnt[FAST_BIT];
      slow_ph = s_q.blk_cnt[SLOW_BIT];

      // Temperature fault outranks unresponsive battery
      if (temp_now) begin
         s_d.chg_oe = s_q.pwm_cnt < duty_on(fast_ph);
      end else if (bad_now) begin
         s_d.chg_oe = s_q.pwm_cnt < duty_on(slow_ph);
      end else begin
         s_d.chg_oe = chg_now;
      end

      // Settle timer restarts whenever regulator three drops out
      // It stops at its terminal count and cannot wrap into a false release
      if (s_q.ctl.en[2] && regulator_three_feedback_ok) begin
         if (s_q.rst_cnt == RST_W'(REGULATOR_THREE_SETTLED_OUT_DELAY - 1)) begin
            s_d.settled = 1'b1;
         end else begin
            s_d.rst_cnt = s_q.rst_cnt + 1'b1;
         end
      end else begin
         s_d.rst_cnt = '0;
         s_d.settled = 1'b0;
      end
      s_d.rst_oe = !s_d.settled;

      // Events; a set in the clear cycle wins
      // Edge detectors reset low, the idle level of each condition
      s_d.temp_q = temp_now;
      s_d.bad_q  = bad_now;
      s_d.chg_q  = chg_now;
      ev = '0;
      ev[IRQ_TEMP]    = temp_now && !s_q.temp_q;
      ev[IRQ_BADBAT]  = bad_now && !s_q.bad_q;
      ev[IRQ_SETTLED] = s_d.settled && !s_q.settled;
      ev[IRQ_CHG_END] = !chg_now && s_q.chg_q;
      s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
      s_d.hresp    = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Registers
   // Reset loads constants only; unlisted fields clear to zero

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q          <= '0;
         s_q.reg_en   <= RST_EN;
         s_q.reg_ilim <= RST_ILIM;
         s_q.reg_mode <= RST_MODE;
         s_q.sp2      <= RST_SP;
         s_q.sp3      <= RST_SP;
         s_q.irq_mask <= RST_MASK;
         s_q.hready   <= 1'b1;
         s_q.rst_oe   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   // Every output is a field of the registered state

   assign hreadyout                      = s_q.hready;
   assign hrdata                         = s_q.hrdata;
   assign hresp                          = s_q.hresp;
   assign ctl                            = s_q.ctl;
   assign regulator_two_feedback_mv      = s_q.sp2_mv;
   assign regulator_three_feedback_mv    = s_q.sp3_mv;
   assign charge_enable                  = s_q.chg_en;
   // Open-drain: the data bit is a constant low
   // Shares the always-zero response flop rather than adding two more
   assign charge_status_out_o            = s_q.hresp;
   assign charge_status_out_oe           = s_q.chg_oe;
   assign regulator_three_settled_out_o  = s_q.hresp;
   assign regulator_three_settled_out_oe = s_q.rst_oe;
   assign irq                            = s_q.irq;

endmodule // pcs_control_select

`default_nettype wire

// file: pcs_far_side.sv
/*
 Far side of the two open-drain status lines: board pull-ups.
 Assumes the block only ever pulls a line low through its enable.
*/
`timescale 1ns/1ns
`default_nettype none
module pcs_far_side (
   // Data bits and enables from the block
   input  wire logic chg_o,
   input  wire logic chg_oe,
   input  wire logic set_o,
   input  wire logic set_oe,
   // Levels the host sees
   output logic      chg_line,
   output logic      set_line
);
   // Released line floats up, never holds its last level
   assign chg_line = chg_oe ? chg_o : 1'b1;
   assign set_line = set_oe ? set_o : 1'b1;
endmodule // pcs_far_side
`default_nettype wire

// file: pcs_control_select_assertions.sv
/*
 Checker bound into the control front end; sees its ports only.
 Assumes one clock domain and the counts of the bound instance.
*/
`timescale 1ns/1ns
`default_nettype none
module pcs_checker
   import pcs_pkg::*;
#(
   parameter int unsigned PWM_PERIOD = 16,
   parameter int unsigned REGULATOR_THREE_SETTLED_OUT_DELAY = 20
) (
   // Clock and reset
   input wire logic            hclk,
   input wire logic            hresetn,
   // Pins and status
   input wire logic            regulator_one_enable_pin,
   input wire logic            regulator_two_enable_pin,
   input wire logic            regulator_three_enable_pin,
   input wire logic            current_limit_select_lo,
   input wire logic            current_limit_select_hi,
   input wire logic            serial_logic_supply,
   input wire logic            scl_pin_level,
   input wire logic            sda_pin_level,
   input wire logic            regulator_three_feedback_ok,
   input wire logic            thermistor_input,
   input wire pcs_chg_in_t     charger,
   // Outputs
   input wire pcs_ctl_t        ctl,
   input wire logic [MV_W-1:0] regulator_three_feedback_mv,
   input wire logic            charge_enable,
   input wire logic            charge_status_out_oe,
   input wire logic            regulator_three_settled_out_oe
);
   wire logic [2:0] pe = {regulator_three_enable_pin, regulator_two_enable_pin,
                          regulator_one_enable_pin};
   wire logic [1:0] pl = {current_limit_select_hi, current_limit_select_lo};
   wire logic       pin = !serial_logic_supply;
   logic [31:0]     sc_q;
   logic [31:0]     sm_q;
   logic            po_q;
   // Settle run and steady run of the status pin during a temperature fault
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sc_q <= '0;
         sm_q <= '0;
         po_q <= 1'b0;
      end else begin
         sc_q <= (ctl.en[2] && regulator_three_feedback_ok) ? sc_q + 1 : '0;
         sm_q <= (thermistor_input && charge_status_out_oe == po_q) ? sm_q + 1 : '0;
         po_q <= charge_status_out_oe;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////
   en_or_a: assert property ($past(hresetn) |-> ($past(pe) & ~ctl.en) == 3'h0)
      else $error("regulator enable lost its pin");
   ilim_or_a: assert property ($past(hresetn) |-> ($past(pl) & ~ctl.ilim) == 2'h0)
      else $error("current limit lost its pin");
   pin_only_a:
   assert property ($past(hresetn) && $past(pin) |-> ctl.en == $past(pe) && ctl.ilim == $past(pl))
      else $error("software bits leak into pin control");
   mode_pins_a:
   assert property ($past(hresetn) && $past(pin)
      |-> ctl.mode == {$past(sda_pin_level), $past(scl_pin_level)})
      else $error("mode does not follow the mode pins");
   pin_setp_a:
   assert property ($past(hresetn) && $past(pin) |-> regulator_three_feedback_mv == 10'h320)
      else $error("set-point not full scale in pin control");
   setp_step_a:
   assert property ($past(hresetn) |-> regulator_three_feedback_mv >= FB_MIN_MV
      && (regulator_three_feedback_mv - FB_MIN_MV) % FB_STEP_MV == 10'h0)
      else $error("set-point off the step grid");
   chg_pause_a:
   assert property ($past(hresetn)
      |-> charge_enable == ($past(charger.request) && !$past(thermistor_input)))
      else $error("charging not paused by temperature");
   chg_low_a:
   assert property ((charger.active && !thermistor_input && !charger.unresponsive)[*3]
      |-> charge_status_out_oe)
      else $error("charging not shown as steady low");
   idle_free_a:
   assert property ((!charger.active && !thermistor_input && !charger.unresponsive)[*3]
      |-> !charge_status_out_oe)
      else $error("idle status line not released");
   blink_run_a: assert property (sm_q <= PWM_PERIOD)
      else $error("fault status not modulated");
   settle_time_a:
   assert property ($fell(regulator_three_settled_out_oe) |-> sc_q >= REGULATOR_THREE_SETTLED_OUT_DELAY - 2)
      else $error("settled output released early");
   settle_hold_a:
   assert property (sc_q > REGULATOR_THREE_SETTLED_OUT_DELAY + 2 |-> !regulator_three_settled_out_oe)
      else $error("settled output never released");
endmodule // pcs_checker
bind pcs_control_select pcs_checker #(.PWM_PERIOD(PWM_PERIOD), .REGULATOR_THREE_SETTLED_OUT_DELAY(REGULATOR_THREE_SETTLED_OUT_DELAY))
   u_chk (.hclk(hclk), .hresetn(hresetn),
      .regulator_one_enable_pin(regulator_one_enable_pin),
      .regulator_two_enable_pin(regulator_two_enable_pin),
      .regulator_three_enable_pin(regulator_three_enable_pin),
      .current_limit_select_lo(current_limit_select_lo),
      .current_limit_select_hi(current_limit_select_hi),
      .serial_logic_supply(serial_logic_supply), .scl_pin_level(scl_pin_level),
      .sda_pin_level(sda_pin_level),
      .regulator_three_feedback_ok(regulator_three_feedback_ok),
      .thermistor_input(thermistor_input), .charger(charger), .ctl(ctl),
      .regulator_three_feedback_mv(regulator_three_feedback_mv),
      .charge_enable(charge_enable), .charge_status_out_oe(charge_status_out_oe),
      .regulator_three_settled_out_oe(regulator_three_settled_out_oe));
`default_nettype wire

// file: tb_top.sv
/*
 Self-checking bench of the control front end: table of pin and
 register cases, then set-point, reset, status and settle tests.
 Assumes the bound checker and the pull-up model of the far side.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import pcs_pkg::*;
;
   logic            hclk = 1'b0;
   logic            hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]     haddr, hwdata, hrdata, rd;
   logic [1:0]      htrans, il_p;
   logic [2:0]      hsize, en_p;
   logic            sup, scl, sda, fb_ok, therm, irq, chg_en;
   logic            chg_oe, set_oe, chg_line, set_line, chg_o, set_o;
   pcs_chg_in_t     chg;
   pcs_ctl_t        ctl;
   logic [MV_W-1:0] mv2, mv3;
   int              n, n_mismatch = 0, checks_done = 0;
   // Row: supply, enable pins, limit pins, sda, scl, CTRL value, expected ctl
   logic [21:0]     rows [6] = '{22'b1_101_00_11_0000010_1110000,
      22'b1_000_01_00_1010000_0001110, 22'b0_010_10_01_1111111_0101001,
      22'b0_000_00_10_1111111_0000010, 22'b1_000_00_11_0100000_0000001,
      22'b0_111_11_11_0000000_1111111};
   logic [7:0]      ra [5] = '{OFS_CTRL, OFS_SETP, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h14};
   logic [31:0]     rv [5] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'h0};

   always #2 hclk = ~hclk;

   pcs_control_select #(.PWM_PERIOD(16), .REGULATOR_THREE_SETTLED_OUT_DELAY(20), .BLINK_SLOW(4), .BLINK_FAST(2))
   u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .regulator_one_enable_pin(en_p[0]), .regulator_two_enable_pin(en_p[1]),
      .regulator_three_enable_pin(en_p[2]), .current_limit_select_lo(il_p[0]),
      .current_limit_select_hi(il_p[1]), .serial_logic_supply(sup), .scl_pin_level(scl),
      .sda_pin_level(sda), .regulator_three_feedback_ok(fb_ok), .thermistor_input(therm),
      .charger(chg), .ctl(ctl), .regulator_two_feedback_mv(mv2),
      .regulator_three_feedback_mv(mv3), .charge_enable(chg_en),
      .charge_status_out_o(chg_o), .charge_status_out_oe(chg_oe),
      .regulator_three_settled_out_o(set_o),
      .regulator_three_settled_out_oe(set_oe), .irq(irq));

   pcs_far_side u_far (.chg_o(chg_o), .chg_oe(chg_oe), .set_o(set_o), .set_oe(set_oe),
      .chg_line(chg_line), .set_line(set_line));
   ////////////////////////////////////////
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
      if (t >= 50) n_mismatch++;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cnt_low(input int w);
      n = 0;
      repeat (w) begin
         @(posedge hclk);
         if (chg_line === 1'b0) n++;
      end
   endtask

   task automatic complete_run();
      if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #80000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = {5'h0, 64'h0, 3'h2};
      {sup, en_p, il_p, sda, scl, fb_ok, therm, chg} = 13'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         {sup, en_p, il_p, sda, scl} <= rows[i][21:14];
         bus(1'b1, OFS_CTRL, {25'h0, rows[i][13:7]});
         repeat (2) @(posedge hclk);
         chk(32'(ctl), {25'h0, rows[i][6:0]});
      end
      bus(1'b1, OFS_STAT, 32'h0);
      bus(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h07F);
      sup <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, OFS_SETP, {24'h0, c[3:0], 4'hF - c[3:0]});
         repeat (2) @(posedge hclk);
         chk(32'(mv2), 32'(FB_MIN_MV + FB_STEP_MV * (10'hF - 10'(c))));
         chk(32'(mv3), 32'(FB_MIN_MV + FB_STEP_MV * 10'(c)));
      end
      sup <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(32'(mv3), 32'h320);
      {sup, en_p, il_p, sda, scl} <= 8'h80;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(32'(ctl), 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      // Charging, then temperature fault with the interrupt enabled
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      chg <= pcs_chg_in_t'(3'b110);
      repeat (4) @(posedge hclk);
      chk(32'(chg_en), 32'h1);
      chk(32'(chg_line), 32'h0);
      therm <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(32'(chg_en), 32'h0);
      chk(32'(irq), 32'h1);
      cnt_low(64);
      chk(32'(n), 32'd32);
      therm <= 1'b0;
      bus(1'b1, OFS_IRQ_STAT, 32'hF);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
      chk(32'(chg_en), 32'h1);
      // Masked event still latches but stays quiet
      bus(1'b1, OFS_IRQ_MASK, 32'h0);
      therm <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h0);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd & 32'h1, 32'h1);
      therm <= 1'b0;
      chg <= pcs_chg_in_t'(3'b001);
      repeat (3) @(posedge hclk);
      cnt_low(128);
      chk(32'(n), 32'd64);
      chg <= pcs_chg_in_t'(3'b000);
      repeat (3) @(posedge hclk);
      cnt_low(16);
      chk(32'(n), 32'd0);
      en_p <= 3'b100;
      fb_ok <= 1'b1;
      repeat (18) @(posedge hclk);
      chk(32'(set_line), 32'h0);
      repeat (6) @(posedge hclk);
      chk(32'(set_line), 32'h1);
      fb_ok <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(32'(set_line), 32'h0);
      // Every event has latched: temperature, bad battery, settled, charge end
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'hF);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
